// ===== common/bts_pkg.sv
// Purpose: constants and carrier types for the burst-of-two DDR SRAM port
// Assumes: x36 organisation, pins sampled by ref_clk at 40 MHz
// Notes: names below are the ones used by logic/bts_port.sv
// Notes on behaviour
// - Each read or write starts at a rising edge of the true input clock.
// - True clock rise captures read address, selects, first masks and data.
// - Complement clock rise captures write address, second masks and data.
// - Write buffer takes beat one half a cycle before the write address.
// - Each beat's own masks decide per lane whether that byte is written.
// - Read beat one leaves at second C# rise, 1.5 cycles after command.
// - Read beat two leaves at the third rise of the true output clock.
// - With both output clocks held high, reads are timed by K and K#.
// - Every read and write moves exactly two beats; burst is fixed.
// - Read and write paths are separate and may run in the same cycle.
// - Reads go through output registers; writes use early-write data.
// - Echo strobes toggle in step with the read data edges.
// - Array is one mebiword of 36 bits; buses and masks follow that.
// - Low write select at K rise registers beat one and starts a write.
// - Low read select at K rise registers address and starts a read.
// - Low mask writes its byte; high mask leaves the byte unchanged.
// - With the locked loop off, read latency is one cycle.
package bts_pkg;

    localparam int DATA_W    = 36;      // Word width, x36 organisation
    localparam int LANE_W    = 9;       // One byte lane with its parity bit
    localparam int LANES     = 4;       // Byte masks per beat
    localparam int ADDR_W    = 19;      // Burst address on the pins
    localparam int MEM_AW    = 20;      // Burst address plus beat bit
    localparam int BUF_DEPTH = 2;       // Read buffer entries

    localparam logic       BEAT0_IDX = 1'b0;
    localparam logic       BEAT1_IDX = 1'b1;
    localparam logic [1:0] CNT_FULL  = 2'h2;
    localparam logic [1:0] CNT_ONE   = 2'h1;

    typedef logic [DATA_W-1:0] bts_word_t;
    typedef logic [LANES-1:0]  bts_mask_t;

    // Every pin that enters from the memory bus
    typedef struct packed {
        logic                k;
        logic                k_n;
        logic                c;
        logic                c_n;
        logic                dll_run;
        logic                rd_sel_n;
        logic                wr_sel_n;
        logic [ADDR_W-1:0]   loc;
        bts_mask_t           mask_n;
        bts_word_t           data;
    } bts_pins_t;

    // One read burst waiting for its output slot
    typedef struct packed {
        logic      arm;
        bts_word_t w0;
        bts_word_t w1;
    } bts_rd_ent_t;

    typedef enum logic {BTS_IDLE, BTS_SECOND} bts_phase_t;

    // Whole state of the port
    typedef struct packed {
        logic                          k_prv;
        logic                          kn_prv;
        logic                          c_prv;
        logic                          cn_prv;
        logic                          a_vld;
        bts_mask_t                     a_mask;
        bts_word_t                     a_data;
        logic                          b_vld;
        logic [ADDR_W-1:0]             b_addr;
        bts_mask_t                     b_mask0;
        bts_mask_t                     b_mask1;
        bts_word_t                     b_d0;
        bts_word_t                     b_d1;
        bts_rd_ent_t [BUF_DEPTH-1:0]   ent;
        logic                          wr_ptr;
        logic                          rd_ptr;
        logic [1:0]                    cnt;
        bts_phase_t                    phase;
        bts_word_t                     q;
        logic                          str_pos;
        logic                          str_neg;
    } bts_state_t;

    localparam bts_state_t BTS_STATE_RST = '0;

endpackage

// ===== logic/bts_port.sv
// Purpose: memory side of a separate-port burst-of-two DDR SRAM
// Assumes: all pins are asynchronous to ref_clk and pass two flip-flops
// Notes: pin clocks are sampled; their edges become one-cycle enables
// Notes: all pins share one sync pipe, so clocks and data stay aligned
// Notes: the link clock must be well below half of ref_clk
// Notes: the array has no reset; unwritten words read back unknown
// Notes: a third read while two bursts wait is dropped, never queued
`timescale 1ns/1ps

module bts_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } bts_sync_t;

    bts_sync_t st_ff;
    bts_sync_t nxt_st;

    // First stage feeds only the second
    // Nothing else reads s1, so a metastable sample never spreads
    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
    end

    // Two-stage register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.s2;
endmodule // bts_sync

module bts_port
    import bts_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    input  wire logic              k,
    input  wire logic              k_n,
    input  wire logic              c,
    input  wire logic              c_n,
    input  wire logic              dll_run,
    input  wire logic              rd_sel_n,
    input  wire logic              wr_sel_n,
    input  wire logic [ADDR_W-1:0] location_in,
    input  wire logic [LANES-1:0]  lane_store_mask_n,
    input  wire logic [DATA_W-1:0] input_bus,
    output logic      [DATA_W-1:0] output_bus,
    output logic                   returned_strobe_pos,
    output logic                   returned_strobe_neg
);
    bts_pins_t   pin_raw;
    bts_pins_t   pins;
    bts_state_t  st_ff;
    bts_state_t  nxt_st;
    bts_word_t   mem [0:(2**MEM_AW)-1];
    logic        k_rise;
    logic        kn_rise;
    logic        c_rise;
    logic        cn_rise;
    logic        use_k;
    logic        opos;
    logic        oneg;
    logic        rd_go;
    logic        wr_go;
    logic        hit;
    logic        commit;
    bts_word_t   fetch0;
    bts_word_t   fetch1;
    bts_rd_ent_t head;
    logic        buf_in_valid;
    logic        buf_in_ready;
    logic        buf_out_valid;
    logic        buf_out_ready;
    logic        launch0;

    // Per-lane merge: a low mask takes the new byte
    // Shared by the array write and the read bypass so both agree
    // on which lanes a buffered write really touches
    function automatic bts_word_t bts_merge(
        input bts_word_t old_w,
        input bts_word_t new_w,
        input bts_mask_t mask_n
    );
        bts_word_t r;
        r = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (!mask_n[i]) begin
                r[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
            end
        end
        return r;
    endfunction

    // Bundle the pins and bring them into the ref_clk domain
    // One wide synchroniser keeps every pin in the same sample slot,
    // so a clock edge is always seen together with its own data
    always_comb begin
        pin_raw          = '0;
        pin_raw.k        = k;
        pin_raw.k_n      = k_n;
        pin_raw.c        = c;
        pin_raw.c_n      = c_n;
        pin_raw.dll_run  = dll_run;
        pin_raw.rd_sel_n = rd_sel_n;
        pin_raw.wr_sel_n = wr_sel_n;
        pin_raw.loc      = location_in;
        pin_raw.mask_n   = lane_store_mask_n;
        pin_raw.data     = input_bus;
    end

    bts_sync #(
        .W ($bits(bts_pins_t))
    ) u_sync (
        .clk  (ref_clk),
        .nrst (nrst),
        .d    (pin_raw),
        .q    (pins)
    );

    // Edge enables from the sampled pin clocks
    // Each enable lasts exactly one ref_clk cycle per pin clock rise
    assign k_rise  = pins.k & ~st_ff.k_prv;
    assign kn_rise = pins.k_n & ~st_ff.kn_prv;
    assign c_rise  = pins.c & ~st_ff.c_prv;
    assign cn_rise = pins.c_n & ~st_ff.cn_prv;

    // Output timing falls back to K and K# when C and C# sit high
    // Raising the hold makes C rise, but both are then high in the
    // same sample, so no stray output edge is taken
    assign use_k = pins.c & pins.c_n;
    assign opos  = use_k ? k_rise : c_rise;
    assign oneg  = use_k ? kn_rise : cn_rise;

    // Commands are taken only at a true input clock rise
    // Selects seen at any other time are ignored with their address
    assign rd_go = k_rise & ~pins.rd_sel_n;
    assign wr_go = k_rise & ~pins.wr_sel_n;

    // Buffered write committed to the array at the next K rise
    // Until then a matching read is served from the buffer instead
    assign commit = k_rise & st_ff.b_vld;
    assign hit    = st_ff.b_vld & (st_ff.b_addr == pins.loc);

    // Array fetch, patched by a write still in the buffer
    // The fetch happens at the command edge; later writes do not
    // change a burst that is already waiting for its output slot
    always_comb begin
        fetch0 = mem[{pins.loc, BEAT0_IDX}];
        fetch1 = mem[{pins.loc, BEAT1_IDX}];
        if (hit) begin
            fetch0 = bts_merge(fetch0, st_ff.b_d0, st_ff.b_mask0);
            fetch1 = bts_merge(fetch1, st_ff.b_d1, st_ff.b_mask1);
        end
    end

    // Read buffer handshake
    // Two entries cover back-to-back reads at full link rate with the loop off; with it running the third one is dropped
    assign head          = st_ff.ent[st_ff.rd_ptr];
    assign buf_in_valid  = rd_go;
    assign buf_in_ready  = st_ff.cnt != CNT_FULL;
    assign buf_out_valid = st_ff.cnt != 2'h0;

    // Beat one: C# after arming, or first C rise with the loop off
    // Arming skips the C# rise inside the command cycle, which gives
    // the one and a half cycle latency with the loop running
    assign launch0 = (st_ff.phase == BTS_IDLE) & buf_out_valid &
                     (pins.dll_run ? (oneg & head.arm) : opos);
    assign buf_out_ready = (st_ff.phase == BTS_SECOND) &
                           (pins.dll_run ? opos : oneg);

    // Next-state logic
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.k_prv  = pins.k;
        nxt_st.kn_prv = pins.k_n;
        nxt_st.c_prv  = pins.c;
        nxt_st.cn_prv = pins.c_n;

        // Write side, independent of the read side
        // Beat one waits in stage a until the write address arrives
        if (k_rise) begin
            nxt_st.b_vld  = 1'b0;
            nxt_st.a_vld  = wr_go;
            if (wr_go) begin
                nxt_st.a_mask = pins.mask_n;
                nxt_st.a_data = pins.data;
            end
        end
        if (kn_rise && st_ff.a_vld) begin
            nxt_st.a_vld   = 1'b0;
            nxt_st.b_vld   = 1'b1;
            nxt_st.b_addr  = pins.loc;
            nxt_st.b_mask0 = st_ff.a_mask;
            nxt_st.b_d0    = st_ff.a_data;
            nxt_st.b_mask1 = pins.mask_n;
            nxt_st.b_d1    = pins.data;
        end

        // Waiting bursts become eligible at the next C# rise
        if (pins.dll_run && oneg) begin
            for (int i = 0; i < BUF_DEPTH; i++) begin
                nxt_st.ent[i].arm = 1'b1;
            end
        end

        // Push a fetched burst
        if (buf_in_valid && buf_in_ready) begin
            nxt_st.ent[st_ff.wr_ptr].arm = 1'b0;
            nxt_st.ent[st_ff.wr_ptr].w0  = fetch0;
            nxt_st.ent[st_ff.wr_ptr].w1  = fetch1;
            nxt_st.wr_ptr = ~st_ff.wr_ptr;
        end

        // Output registers drive the two beats
        if (launch0) begin
            nxt_st.q     = head.w0;
            nxt_st.phase = BTS_SECOND;
        end
        if (buf_out_ready) begin
            nxt_st.q      = head.w1;
            nxt_st.phase  = BTS_IDLE;
            nxt_st.rd_ptr = ~st_ff.rd_ptr;
        end

        // Occupancy follows push and pop
        // A push and a pop in one cycle leave the count unchanged
        if ((buf_in_valid && buf_in_ready) && !buf_out_ready) begin
            nxt_st.cnt = st_ff.cnt + CNT_ONE;
        end else if (!(buf_in_valid && buf_in_ready) && buf_out_ready) begin
            nxt_st.cnt = st_ff.cnt - CNT_ONE;
        end

        // Echo strobes switch on the same edges as the data
        // They run on every output edge, also with no read pending
        if (opos) begin
            nxt_st.str_pos = 1'b1;
            nxt_st.str_neg = 1'b0;
        end else if (oneg) begin
            nxt_st.str_pos = 1'b0;
            nxt_st.str_neg = 1'b1;
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= BTS_STATE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Array write of both beats, lanes chosen per beat
    // No reset here: the array holds data only, never control state
    always_ff @(posedge ref_clk) begin
        if (commit) begin
            mem[{st_ff.b_addr, BEAT0_IDX}] <=
                bts_merge(mem[{st_ff.b_addr, BEAT0_IDX}],
                          st_ff.b_d0, st_ff.b_mask0);
            mem[{st_ff.b_addr, BEAT1_IDX}] <=
                bts_merge(mem[{st_ff.b_addr, BEAT1_IDX}],
                          st_ff.b_d1, st_ff.b_mask1);
        end
    end

    assign output_bus          = st_ff.q;
    assign returned_strobe_pos = st_ff.str_pos;
    assign returned_strobe_neg = st_ff.str_neg;
endmodule // bts_port

// ===== tb/bts_port_monitor.sv
// Purpose: pin-level assertions on bts_port
// Assumes: pin edges reach the outputs 3 to 5 ref_clk cycles later
// Notes: attached by bind from the bench top
`timescale 1ns/1ps

module bts_port_monitor
    import bts_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              nrst,
    input wire logic              k,
    input wire logic              k_n,
    input wire logic              c,
    input wire logic              c_n,
    input wire logic              rd_sel_n,
    input wire logic [DATA_W-1:0] output_bus,
    input wire logic              returned_strobe_pos,
    input wire logic              returned_strobe_neg
);
    logic [5:0] rd_age_ff;
    logic [5:0] edge_age_ff;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // Cycles since the last read select and the last output clock rise
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_age_ff   <= 6'h3f;
            edge_age_ff <= 6'h3f;
        end else begin
            rd_age_ff   <= !rd_sel_n ? 6'h00
                         : rd_age_ff + {5'h00, ~&rd_age_ff};
            edge_age_ff <= ($rose(c) || $rose(c_n)
                         || (c && c_n && ($rose(k) || $rose(k_n)))) ? 6'h00
                         : edge_age_ff + {5'h00, ~&edge_age_ff};
        end
    end

    sequence s_pos;
        returned_strobe_pos && !returned_strobe_neg;
    endsequence
    sequence s_neg;
        returned_strobe_neg && !returned_strobe_pos;
    endsequence

    AST_POS_AFTER_C: assert property ($rose(c) && !c_n |-> ##[3:5] s_pos)
        else $error("strobe pos missed a true output edge");
    AST_NEG_AFTER_CN: assert property ($rose(c_n) && !c |-> ##[3:5] s_neg)
        else $error("strobe neg missed a comp output edge");
    AST_POS_AFTER_K_HELD: assert property ($rose(k) && c && c_n |-> ##[3:5] s_pos)
        else $error("held output clocks: strobe pos missed k");
    AST_NEG_AFTER_KN_HELD: assert property ($rose(k_n) && c && c_n |-> ##[3:5] s_neg)
        else $error("held output clocks: strobe neg missed k_n");
    AST_DATA_WITH_STROBE: assert property (!$stable(output_bus) |->
        !$stable({returned_strobe_pos, returned_strobe_neg}))
        else $error("read data moved without a strobe edge");
    AST_STROBES_OPPOSITE: assert property ((returned_strobe_pos
        || returned_strobe_neg) |=> returned_strobe_pos != returned_strobe_neg)
        else $error("strobes not complementary");
    AST_DATA_NEEDS_READ: assert property (!$stable(output_bus) |->
        rd_age_ff inside {[2:24]})
        else $error("read data moved with no read in flight");
    AST_DATA_ON_EDGE: assert property (!$stable(output_bus) |->
        edge_age_ff inside {[1:5]})
        else $error("read data moved away from an output edge");
endmodule // bts_port_monitor

// ===== tb/bts_host_model.sv
// Purpose: host controller model driving the memory pins
// Assumes: link clock of 200 ns, free running from 13 ns
// Notes: tasks begin 50 ns before a true clock rise
`timescale 1ns/1ps

module bts_host_model
    import bts_pkg::*;
(
    output logic              k,
    output logic              k_n,
    output logic              c,
    output logic              c_n,
    output logic              dll_run,
    output logic              rd_sel_n,
    output logic              wr_sel_n,
    output logic [ADDR_W-1:0] location_in,
    output logic [LANES-1:0]  lane_store_mask_n,
    output logic [DATA_W-1:0] input_bus
);
    logic hold_c;

    // Output clocks follow the input pair unless both are held high
    assign k_n = ~k;
    assign c   = hold_c | k;
    assign c_n = hold_c | k_n;

    // Idle pins, then a free-running input clock
    initial begin
        {hold_c, dll_run, rd_sel_n, wr_sel_n} = 4'h7;
        location_in       = '0;
        lane_store_mask_n = '1;
        input_bus         = '0;
        k                 = 1'b0;
        #13;
        forever #100 k = ~k;
    end

    task automatic align();
        @(negedge k);
        #50;
    endtask

    // Beat one goes with the command, beat two with the k_n rise
    task automatic cycle(input logic rd, wr, input logic [ADDR_W-1:0] ra, wa,
                         input bts_word_t d0, d1, input bts_mask_t m0, m1);
        {rd_sel_n, wr_sel_n} = {~rd, ~wr};
        location_in       = ra;
        input_bus         = d0;
        lane_store_mask_n = m0;
        #100;
        {rd_sel_n, wr_sel_n} = 2'h3;
        location_in       = wa;
        input_bus         = d1;
        lane_store_mask_n = m1;
        #100;
    endtask

    // Released lines carry a pattern that flips every half cycle
    task automatic idle(input int n);
        repeat (2 * n) begin
            location_in       = ~location_in;
            input_bus         = ~input_bus;
            lane_store_mask_n = ~lane_store_mask_n;
            #100;
        end
    endtask

    task automatic mode(input logic dll, hold);
        dll_run = dll;
        hold_c  = hold;
    endtask
endmodule // bts_host_model

// ===== tb/burst_two_ddr_sram_port_test.sv
// Purpose: self-checking bench for bts_port
// Assumes: ref_clk 40 MHz, link clock 200 ns
// Notes: read beats are sampled midway between output edges
`timescale 1ns/1ps

module burst_two_ddr_sram_port_test
    import bts_pkg::*;
;
    localparam logic [ADDR_W-1:0] ADR_A = 19'h0_0012;
    localparam logic [ADDR_W-1:0] ADR_B = 19'h4_0021;
    localparam bts_word_t         X0    = 36'h3_3333_cccc;
    localparam bts_word_t         X1    = 36'hc_cccc_3333;

    logic              ref_clk, nrst, k, k_n, c, c_n, dll_run;
    logic              rd_sel_n, wr_sel_n;
    logic [ADDR_W-1:0] location_in;
    bts_mask_t         lane_store_mask_n;
    bts_word_t         input_bus, output_bus, a0, a1;
    logic              returned_strobe_pos, returned_strobe_neg;
    logic [1:0]        st;
    int                mismatches;
    int                n_checks;

    assign st = {returned_strobe_pos, returned_strobe_neg};

    bts_host_model u_bts_host_model (.k, .k_n, .c, .c_n, .dll_run,
        .rd_sel_n, .wr_sel_n, .location_in, .lane_store_mask_n, .input_bus);
    bts_port u_bts_port (.ref_clk, .nrst, .k, .k_n, .c, .c_n, .dll_run,
        .rd_sel_n, .wr_sel_n, .location_in, .lane_store_mask_n, .input_bus,
        .output_bus, .returned_strobe_pos, .returned_strobe_neg);

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input bts_word_t got, exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Per-lane merge of a masked write into the old word
    function automatic bts_word_t merge(bts_word_t o, n, bts_mask_t m);
        merge = o;
        for (int i = 0; i < LANES; i++)
            if (!m[i]) merge[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
    endfunction

    // Compare beats and strobes one output edge apart
    task automatic watch(input int dly, input logic neg1, bts_word_t w[$]);
        #dly;
        foreach (w[i]) begin
            chk(output_bus, w[i]);
            chk(bts_word_t'(st), (neg1 ^ i[0]) ? 36'h1 : 36'h2);
            #100;
        end
    endtask

    task automatic read_back(input logic [ADDR_W-1:0] a, input int dly,
                             input logic neg1, input bts_word_t e0, e1);
        u_bts_host_model.cycle(1'b1, 1'b0, a, a, e1, e0, a[3:0], ~a[3:0]);
        fork
            u_bts_host_model.idle(3);
            watch(dly, neg1, '{e0, e1});
        join
    endtask

    task automatic test_write_read();
        a0 = 36'h1_2345_6789;
        a1 = 36'h9_8765_4321;
        u_bts_host_model.cycle(1'b0, 1'b1, ADR_B, ADR_A, a0, a1, '0, '0);
        u_bts_host_model.idle(1);
        read_back(ADR_A, 300, 1'b1, a0, a1);
        $display("test_write_read done");
    endtask

    task automatic test_masks();
        u_bts_host_model.cycle(1'b0, 1'b1, ADR_A, ADR_A, X1, X0, 4'h5, 4'ha);
        a0 = merge(a0, X1, 4'h5);
        a1 = merge(a1, X0, 4'ha);
        u_bts_host_model.idle(1);
        read_back(ADR_A, 300, 1'b1, a0, a1);
        $display("test_masks done");
    endtask

    task automatic test_concurrent();
        u_bts_host_model.cycle(1'b1, 1'b1, ADR_A, ADR_B, X0, X1, '0, '0);
        u_bts_host_model.cycle(1'b1, 1'b0, ADR_B, ADR_B, X1, X0, a0[3:0], a1[3:0]);
        fork
            u_bts_host_model.idle(4);
            watch(100, 1'b1, '{a0, a1, X0, X1});
        join
        $display("test_concurrent done");
    endtask

    task automatic test_loop_off();
        u_bts_host_model.mode(1'b0, 1'b0);
        u_bts_host_model.cycle(1'b0, 1'b0, ADR_A, ADR_A, '1, '1, '0, '0);
        u_bts_host_model.idle(1);
        read_back(ADR_A, 200, 1'b0, a0, a1);
        u_bts_host_model.mode(1'b1, 1'b0);
        u_bts_host_model.idle(1);
        $display("test_loop_off done");
    endtask

    task automatic test_held_clocks();
        u_bts_host_model.mode(1'b1, 1'b1);
        u_bts_host_model.idle(1);
        read_back(ADR_B, 300, 1'b1, X0, X1);
        u_bts_host_model.mode(1'b1, 1'b0);
        $display("test_held_clocks done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Reset, then the scenarios in turn
    initial begin
        mismatches = 0;
        n_checks   = 0;
        nrst       = 1'b0;
        repeat (3) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (3) @(negedge ref_clk);
        u_bts_host_model.align();
        test_write_read();
        test_masks();
        test_concurrent();
        test_loop_off();
        test_held_clocks();
        wrap_up();
    end

    // Scenarios need about 6.3 us; cut a hang well after that
    initial begin
        #50000;
        mismatches++;
        wrap_up();
    end
endmodule // burst_two_ddr_sram_port_test

bind bts_port bts_port_monitor u_bts_port_monitor (.ref_clk, .nrst, .k,
    .k_n, .c, .c_n, .rd_sel_n, .output_bus, .returned_strobe_pos,
    .returned_strobe_neg);
